// file: pss_pkg.sv
// Package: shared constants and carrier types for the scan sequencer
package pss_pkg;
  // ==========================================
  // Timing
  localparam int unsigned PSS_CLK_HZ = 125000000;
  localparam int unsigned PSS_TICK_MS = 10;
  localparam int unsigned PSS_TICK_CYCLES = PSS_CLK_HZ / 1000 * PSS_TICK_MS;
  localparam int unsigned PSS_WDOG_S = 3;
  localparam longint unsigned PSS_WDOG_CYCLES = longint'(PSS_CLK_HZ) * PSS_WDOG_S;
  // ==========================================
  // Widths and ranges
  localparam int unsigned PSS_PC_W = 16;
  localparam int unsigned PSS_ROUTINES = 64;
  localparam int unsigned PSS_RNUM_W = 6;
  localparam int unsigned PSS_SLOT_W = 7;
  localparam int unsigned PSS_DATA_W = 16;
  localparam int unsigned PSS_PERIOD_W = 10;
  localparam int unsigned PSS_STACK_DEPTH = 8;
  localparam logic [PSS_PERIOD_W-1:0] PSS_PERIOD_MIN = 10'h001;
  localparam logic [PSS_PERIOD_W-1:0] PSS_PERIOD_MAX = 10'h3E7;
  localparam logic [PSS_PC_W-1:0] PSS_PC_START = 16'h0000;
  localparam logic [PSS_SLOT_W-1:0] PSS_SLOT_FIRST = 7'h00;
  // ==========================================
  // Decoded instruction opcodes
  typedef enum logic [3:0] {
    PSS_OP_NOP = 4'h0,
    PSS_OP_INVOKE = 4'h1,
    PSS_OP_ENTRY = 4'h2,
    PSS_OP_EXIT = 4'h3,
    PSS_OP_PSTART = 4'h4,
    PSS_OP_PEXIT = 4'h5,
    PSS_OP_INREF = 4'h6,
    PSS_OP_OUTREF = 4'h7,
    PSS_OP_KICK = 4'h8,
    PSS_OP_TERM = 4'h9,
    PSS_OP_FETCH = 4'hA
  } pss_op_type;
  // Instruction word from program memory
  typedef struct packed {
    pss_op_type op;
    logic cond;
    logic [PSS_RNUM_W-1:0] routine_number;
    logic [PSS_SLOT_W-1:0] io_slot_address;
    logic [PSS_SLOT_W-1:0] slot_number;
    logic [PSS_DATA_W-1:0] word_count;
    logic [PSS_DATA_W-1:0] module_start_address;
    logic [PSS_DATA_W-1:0] destination_start;
  } pss_instr_type;
  // Backplane request to a slot
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [PSS_SLOT_W-1:0] slot;
    logic [PSS_DATA_W-1:0] addr;
  } pss_bus_req_type;
  // Store into data memory
  typedef struct packed {
    logic valid;
    logic [PSS_DATA_W-1:0] addr;
    logic [PSS_DATA_W-1:0] data;
  } pss_store_type;
endpackage

// file: pss_period_timer.sv
// Periodic block timebase: ten millisecond ticks, interval of the clamped period_setting plus one
`timescale 1ns/1ps
`default_nettype none
module pss_period_timer
  import pss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PSS_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [PSS_PERIOD_W-1:0] period_setting_i,
  input wire logic taken_i,
  output logic due_o
);
  // ==========================================
  // Counters
  logic [31:0] tick_count; // Cycles within one tick
  logic [PSS_PERIOD_W:0] tick_total; // Ticks since last due
  wire tick_end = (tick_count == TICK_CYCLES - 1);
  // Clamp the setting into its legal span
  wire [PSS_PERIOD_W-1:0] period_legal = (period_setting_i < PSS_PERIOD_MIN) ? PSS_PERIOD_MIN :
    (period_setting_i > PSS_PERIOD_MAX) ? PSS_PERIOD_MAX : period_setting_i;
  wire interval_end = tick_end && (tick_total == {1'b0, period_legal}); // see [RQ7]
  // ==========================================
  // Free running timebase, independent of the scan
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_count <= '0;
      tick_total <= '0;
      due_o <= 1'b0;
    end else if (enable_i) begin
      tick_count <= tick_end ? '0 : tick_count + 32'd1;
      if (interval_end) begin
        tick_total <= '0;
      end else if (tick_end) begin
        tick_total <= tick_total + 1'b1;
      end
      // Set wins over taken so no interval is lost
      if (interval_end) begin
        due_o <= 1'b1;
      end else if (taken_i) begin
        due_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: pss_sequencer.sv
// Scan sequencer: input read, program walk, output update, routines and watchdog
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Invoke jumps to entry with same number
// [RQ2] Exit returns after the invoking instruction
// [RQ3] Sixty four routine numbers, zero to 63
// [RQ4] Routine bodies placed after invocations
// [RQ5] Each routine number has one entry
// [RQ6] Act every scan while condition true
// [RQ7] Periodic block every (setting+1) times 10 ms
// [RQ8] Periodic block only while flag on
// [RQ9] At most one periodic block
// [RQ10] Periodic block shorter than scan
// [RQ11] Read inputs first, update outputs last
// [RQ12] Input refresh fetches one slot now
// [RQ13] Output refresh drives one slot now
// [RQ14] Watchdog limit defaults to three seconds
// [RQ15] Watchdog expiry flags error and stops
// [RQ16] Kick restarts the watchdog count
// [RQ17] Terminator marks end of program
// [RQ18] Fetch copies module words to destination
// [RQ19] Backplane slots numbered from zero
// [RQ20] Keep return addresses, restart watchdog per scan
module pss_sequencer
  import pss_pkg::*;
#(
  parameter longint unsigned WDOG_CYCLES = PSS_WDOG_CYCLES,
  parameter int unsigned TICK_CYCLES = PSS_TICK_CYCLES,
  parameter int unsigned SLOTS = 2 ** PSS_SLOT_W,
  parameter int unsigned STACK_DEPTH = PSS_STACK_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i, // Clock enable, freezes all state when low
  input wire logic run_i, // Start scanning from stop mode
  input wire logic periodic_enable_flag_i,
  input wire logic [PSS_PERIOD_W-1:0] period_setting_i,
  input wire logic [PSS_PC_W-1:0] periodic_entry_pc_i, // Location of the periodic block start
  input wire pss_instr_type instr_i, // Instruction at pc_o, valid the next cycle
  input wire logic [PSS_DATA_W-1:0] bus_rdata_i, // Backplane read data
  input wire logic bus_ack_i, // Backplane answer to bus_req_o
  input wire logic [PSS_DATA_W-1:0] out_image_i, // Output image word for bus_req_o.slot
  output logic [PSS_PC_W-1:0] pc_o,
  output pss_bus_req_type bus_req_o,
  output logic [PSS_DATA_W-1:0] bus_wdata_o,
  output pss_store_type in_image_o, // Input image store, addressed by slot
  output pss_store_type dest_store_o, // Fetch destination store
  output logic running_o,
  output logic wdog_error_o,
  output logic scan_done_o
);
  // ==========================================
  // State
  typedef enum logic [2:0] {
    PSS_STOP, PSS_IN_SCAN, PSS_FETCH_INSTR, PSS_EXEC, PSS_BUS_WAIT, PSS_OUT_SCAN
  } pss_state_type;
  pss_state_type state; // Sequencer state
  logic [PSS_PC_W-1:0] entry_pc [PSS_ROUTINES]; // Entry locations by routine number
  logic [PSS_PC_W-1:0] ret_stack [STACK_DEPTH]; // Return addresses
  logic [$clog2(STACK_DEPTH):0] sp; // Stack depth in use
  logic [PSS_PC_W-1:0] periodic_ret; // Where the interrupted scan resumes
  logic in_periodic; // Inside the periodic block
  logic [PSS_SLOT_W-1:0] io_slot; // Slot walker for full refresh
  logic [PSS_DATA_W-1:0] words_left; // Fetch words remaining
  logic [PSS_DATA_W-1:0] dest_ptr; // Fetch destination pointer
  logic [63:0] wdog_count; // Watchdog count
  logic periodic_due; // Periodic interval elapsed
  // ==========================================
  // Decoding
  // Last slot of the walk, used by both refresh scans
  function automatic logic slot_last(input logic [PSS_SLOT_W-1:0] s);
    slot_last = (s == PSS_SLOT_W'(SLOTS - 1));
  endfunction
  wire active = instr_i.cond; // see [RQ6]
  wire take_periodic = periodic_due && periodic_enable_flag_i && !in_periodic && state == PSS_FETCH_INSTR; // see [RQ8]
  wire [PSS_PC_W-1:0] pc_next = pc_o + 1'b1;
  wire wdog_expire = (wdog_count >= WDOG_CYCLES - 1) && running_o; // see [RQ14]
  // First cycle of a scan only; a slot zero request left waiting must not keep refreshing the count
  wire scan_start = (state == PSS_IN_SCAN) && (io_slot == PSS_SLOT_FIRST) && !bus_req_o.valid;
  wire stack_full = (sp == ($clog2(STACK_DEPTH)+1)'(STACK_DEPTH));
  wire fetch_last = (words_left <= 16'h0001);
  // ==========================================
  // Periodic timebase
  pss_period_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .period_setting_i(period_setting_i),
    .taken_i(take_periodic),
    .due_o(periodic_due)
  );
  // ==========================================
  // Watchdog, restarted at each scan start and by the kick op
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wdog_count <= '0;
    end else if (enable_i) begin
      if (scan_start || !running_o) begin
        // Stop mode holds zero so a restart gets a full span
        wdog_count <= '0; // see [RQ20]
      end else if (state == PSS_EXEC && instr_i.op == PSS_OP_KICK && active) begin
        wdog_count <= '0; // see [RQ16]
      end else if (running_o) begin
        wdog_count <= wdog_count + 64'd1;
      end
    end
  end
  // ==========================================
  // Main sequencer
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= PSS_STOP;
      pc_o <= PSS_PC_START;
      sp <= '0;
      periodic_ret <= PSS_PC_START;
      in_periodic <= 1'b0;
      io_slot <= PSS_SLOT_FIRST; // see [RQ19]
      words_left <= '0;
      dest_ptr <= '0;
      bus_req_o <= '0;
      bus_wdata_o <= '0;
      in_image_o <= '0;
      dest_store_o <= '0;
      running_o <= 1'b0;
      wdog_error_o <= 1'b0;
      scan_done_o <= 1'b0;
      for (int i = 0; i < PSS_ROUTINES; i++) begin
        entry_pc[i] <= PSS_PC_START;
      end
      for (int i = 0; i < STACK_DEPTH; i++) begin
        ret_stack[i] <= PSS_PC_START;
      end
    end else if (enable_i) begin
      in_image_o.valid <= 1'b0;
      dest_store_o.valid <= 1'b0;
      scan_done_o <= 1'b0;
      if (wdog_expire) begin
        // Overrun: flag and halt into stop mode
        wdog_error_o <= 1'b1; // see [RQ15]
        running_o <= 1'b0;
        bus_req_o <= '0;
        state <= PSS_STOP;
      end else begin
        unique case (state)
          PSS_STOP: begin
            if (run_i) begin
              wdog_error_o <= 1'b0;
              running_o <= 1'b1;
              io_slot <= PSS_SLOT_FIRST;
              state <= PSS_IN_SCAN;
            end
          end
          PSS_IN_SCAN: begin
            // Read every input slot before the program runs
            if (!bus_req_o.valid) begin
              bus_req_o <= '{valid: 1'b1, write: 1'b0, fetch: 1'b0, slot: io_slot, addr: '0}; // see [RQ11]
            end else if (bus_ack_i) begin
              bus_req_o.valid <= 1'b0;
              in_image_o <= '{valid: 1'b1, addr: PSS_DATA_W'(io_slot), data: bus_rdata_i};
              io_slot <= io_slot + 1'b1;
              if (slot_last(io_slot)) begin
                pc_o <= PSS_PC_START;
                sp <= '0;
                state <= PSS_FETCH_INSTR;
              end
            end
          end
          PSS_FETCH_INSTR: begin
            // Periodic block preempts the scan at an instruction boundary
            if (take_periodic) begin
              periodic_ret <= pc_o; // see [RQ7]
              in_periodic <= 1'b1;
              pc_o <= periodic_entry_pc_i;
            end else begin
              state <= PSS_EXEC;
            end
          end
          PSS_EXEC: begin
            pc_o <= pc_next;
            state <= PSS_FETCH_INSTR;
            unique case (instr_i.op)
              PSS_OP_ENTRY: begin
                // Learn routine location as the walk passes it
                entry_pc[instr_i.routine_number] <= pc_o; // see [RQ3]
                if (sp == '0 && !in_periodic) begin
                  pc_o <= pc_next; // Body reached outside a call: walk straight on
                end
              end
              PSS_OP_INVOKE: begin
                if (active && !stack_full) begin
                  ret_stack[sp[$clog2(STACK_DEPTH)-1:0]] <= pc_next; // see [RQ20]
                  sp <= sp + 1'b1;
                  pc_o <= entry_pc[instr_i.routine_number] + 1'b1; // see [RQ1]
                end
              end
              PSS_OP_EXIT: begin
                if (sp != '0) begin
                  sp <= sp - 1'b1;
                  pc_o <= ret_stack[sp[$clog2(STACK_DEPTH)-1:0] - 1'b1]; // see [RQ2]
                end
              end
              PSS_OP_PEXIT: begin
                if (in_periodic) begin
                  in_periodic <= 1'b0;
                  pc_o <= periodic_ret;
                end
              end
              PSS_OP_PSTART: begin
                if (!in_periodic) begin
                  pc_o <= pc_next; // Outside the block: walk straight on to the next instruction, as NOP does
                end
              end
              PSS_OP_INREF, PSS_OP_OUTREF: begin
                if (active) begin
                  // Single slot refresh in the middle of the program
                  bus_req_o <= '{valid: 1'b1, write: (instr_i.op == PSS_OP_OUTREF), fetch: 1'b0,
                    slot: instr_i.io_slot_address, addr: '0}; // see [RQ12]
                  bus_wdata_o <= out_image_i; // see [RQ13]
                  pc_o <= pc_o;
                  state <= PSS_BUS_WAIT;
                end
              end
              PSS_OP_FETCH: begin
                if (active && instr_i.word_count != '0) begin
                  bus_req_o <= '{valid: 1'b1, write: 1'b0, fetch: 1'b1,
                    slot: instr_i.slot_number, addr: instr_i.module_start_address}; // see [RQ18]
                  words_left <= instr_i.word_count;
                  dest_ptr <= instr_i.destination_start;
                  pc_o <= pc_o;
                  state <= PSS_BUS_WAIT;
                end
              end
              PSS_OP_TERM: begin
                // End of program: move on to the output update
                io_slot <= PSS_SLOT_FIRST; // see [RQ17]
                state <= PSS_OUT_SCAN;
              end
              default: begin
              end
            endcase
          end
          PSS_BUS_WAIT: begin
            if (bus_ack_i) begin
              if (bus_req_o.fetch) begin
                dest_store_o <= '{valid: 1'b1, addr: dest_ptr, data: bus_rdata_i}; // see [RQ18]
                dest_ptr <= dest_ptr + 1'b1;
                words_left <= words_left - 1'b1;
                bus_req_o.addr <= bus_req_o.addr + 1'b1;
              end else if (!bus_req_o.write) begin
                in_image_o <= '{valid: 1'b1, addr: PSS_DATA_W'(bus_req_o.slot), data: bus_rdata_i};
              end
              if (!bus_req_o.fetch || fetch_last) begin
                bus_req_o.valid <= 1'b0;
                pc_o <= pc_next;
                state <= PSS_FETCH_INSTR;
              end
            end
          end
          PSS_OUT_SCAN: begin
            // Write every output slot after the program ends
            if (!bus_req_o.valid) begin
              bus_req_o <= '{valid: 1'b1, write: 1'b1, fetch: 1'b0, slot: io_slot, addr: '0}; // see [RQ11]
              bus_wdata_o <= out_image_i;
            end else if (bus_ack_i) begin
              bus_req_o.valid <= 1'b0;
              io_slot <= io_slot + 1'b1;
              if (slot_last(io_slot)) begin
                scan_done_o <= 1'b1;
                io_slot <= PSS_SLOT_FIRST;
                state <= PSS_IN_SCAN;
              end
            end
          end
          default: state <= PSS_STOP;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: pss_seq_chk.sv
// Checker: port assertions for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_seq_chk
  import pss_pkg::*;
#(
  parameter longint unsigned WDOG_CYCLES = PSS_WDOG_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic run_i,
  input wire logic bus_ack_i,
  input wire logic [PSS_DATA_W-1:0] bus_rdata_i,
  input wire pss_bus_req_type bus_req_o,
  input wire pss_store_type in_image_o,
  input wire pss_store_type dest_store_o,
  input wire logic running_o,
  input wire logic wdog_error_o,
  input wire logic scan_done_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // Cycles since scan start; kicks only shorten the design's count
  longint unsigned scan_cnt;
  always_ff @(posedge clock_i) begin
    if (reset_i || scan_done_o || !running_o) begin
      scan_cnt <= '0;
    end else if (enable_i) begin
      scan_cnt <= scan_cnt + 1;
    end
  end
  // ==========================================
  // Assertions
  req_hold_a:
    assert property (bus_req_o.valid && !bus_ack_i |=> $rose(wdog_error_o) || (bus_req_o.valid && $stable(bus_req_o)))
    else $error("request changed before ack");
  in_capture_a:
    assert property (enable_i && bus_req_o.valid && bus_ack_i && !bus_req_o.write && !bus_req_o.fetch
      |=> in_image_o.valid && in_image_o.addr == {9'h000, $past(bus_req_o.slot)} && in_image_o.data == $past(bus_rdata_i))
    else $error("input word not stored");
  fetch_store_a:
    assert property (enable_i && bus_req_o.valid && bus_ack_i && bus_req_o.fetch
      |=> dest_store_o.valid && dest_store_o.data == $past(bus_rdata_i))
    else $error("fetched word not stored");
  run_start_a:
    assert property (enable_i && run_i && !running_o |=> running_o)
    else $error("run did not start a scan");
  first_read_a:
    assert property ($rose(running_o) |=> bus_req_o.valid && !bus_req_o.write && bus_req_o.slot == PSS_SLOT_FIRST)
    else $error("scan did not begin at slot zero");
  wdog_stop_a:
    assert property ($rose(wdog_error_o) |-> !running_o)
    else $error("still running after expiry");
  err_sticky_a:
    assert property (wdog_error_o && !run_i |=> wdog_error_o)
    else $error("error flag dropped without run");
  wdog_late_a:
    assert property ($rose(wdog_error_o) |-> scan_cnt + 4 >= WDOG_CYCLES)
    else $error("watchdog fired early");
  in_pulse_a:
    assert property (in_image_o.valid |=> !in_image_o.valid)
    else $error("input store not a pulse");
  cover property (dest_store_o.valid);
  cover property ($rose(wdog_error_o));
  cover property (scan_done_o);
endmodule
bind pss_sequencer pss_seq_chk #(.WDOG_CYCLES(WDOG_CYCLES)) pss_seq_chk_i (.clock_i(clock_i), .reset_i(reset_i),
  .enable_i(enable_i), .run_i(run_i), .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i), .bus_req_o(bus_req_o),
  .in_image_o(in_image_o), .dest_store_o(dest_store_o), .running_o(running_o), .wdog_error_o(wdog_error_o),
  .scan_done_o(scan_done_o));
`default_nettype wire

// file: pss_slot_model.sv
// Backplane slot model: answers each request after a random wait
`timescale 1ns/1ps
`default_nettype none
module pss_slot_model
  import pss_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire pss_bus_req_type bus_req_i,
  input wire logic stall_i,
  input wire logic [1:0] rnd_i,
  output logic bus_ack_o,
  output logic [PSS_DATA_W-1:0] bus_rdata_o
);
  logic [1:0] wait_cnt; // Cycles left before answering
  // ==========================================
  // One ack per request; data goes inverse once released
  always @(negedge clock_i) begin
    if (reset_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 16'h0000;
      wait_cnt <= 2'h0;
    end else if (bus_ack_o) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      wait_cnt <= rnd_i;
    end else if (bus_req_i.valid && !stall_i) begin
      if (wait_cnt == 2'h0) begin
        // Slot field used as is, first slot is zero
        bus_ack_o <= 1'b1;
        bus_rdata_o <= bus_req_i.fetch ? {1'b1, bus_req_i.slot, bus_req_i.addr[7:0]} : {1'b0, bus_req_i.slot, 8'hA5};
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench: program memory, reference counts and scan scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pss_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic run_i = 1'b0;
  logic flag = 1'b0;
  logic stall = 1'b0; // Partner stops answering
  logic cond = 1'b0; // Condition of the invoke
  logic [PSS_DATA_W-1:0] oimg = 16'h0000;
  logic [31:0] seed = 32'h0000_d4a6;
  logic [1:0] rnd = 2'h0;
  pss_instr_type instr = '0;
  pss_bus_req_type req;
  pss_store_type in_st, dst;
  logic [PSS_PC_W-1:0] pc;
  logic [PSS_DATA_W-1:0] wdata, rdata;
  logic ack, running, werr, done;
  int err_count = 0, cmp_count = 0, ic = 0, wc = 0, bc = 0, pcnt = 0, es, n;
  always #4 clock_i = ~clock_i;
  pss_sequencer #(.WDOG_CYCLES(6000), .TICK_CYCLES(10)) pss_sequencer_i (.clock_i(clock_i), .reset_i(reset_i),
    .enable_i(1'b1), .run_i(run_i), .periodic_enable_flag_i(flag), .period_setting_i(10'h001),
    .periodic_entry_pc_i(16'h0009), .instr_i(instr), .bus_rdata_i(rdata), .bus_ack_i(ack), .out_image_i(oimg),
    .pc_o(pc), .bus_req_o(req), .bus_wdata_o(wdata), .in_image_o(in_st), .dest_store_o(dst), .running_o(running),
    .wdog_error_o(werr), .scan_done_o(done));
  pss_slot_model pss_slot_model_i (.clock_i(clock_i), .reset_i(reset_i), .bus_req_i(req), .stall_i(stall),
    .rnd_i(rnd), .bus_ack_o(ack), .bus_rdata_o(rdata));
  // ==========================================
  // Program: routine body placed after its invoke, one periodic block after the terminator
  function automatic pss_instr_type prog(input logic [PSS_PC_W-1:0] a);
    case (a)
      16'h0000: return '{PSS_OP_INREF, 1'b1, 6'h00, 7'h05, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0001: return '{PSS_OP_INVOKE, cond, 6'h3F, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0002: return '{PSS_OP_OUTREF, 1'b1, 6'h00, 7'h03, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0003: return '{PSS_OP_KICK, 1'b1, 6'h00, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0004: return '{PSS_OP_ENTRY, 1'b1, 6'h3F, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0005: return '{PSS_OP_FETCH, 1'b1, 6'h00, 7'h00, 7'h00, 16'h0003, 16'h0010, 16'h0100};
      16'h0006: return '{PSS_OP_EXIT, 1'b1, 6'h3F, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0008: return '{PSS_OP_PSTART, 1'b1, 6'h00, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      16'h0009: return '{PSS_OP_FETCH, 1'b1, 6'h00, 7'h00, 7'h01, 16'h0001, 16'h0020, 16'h0200};
      16'h000A: return '{PSS_OP_PEXIT, 1'b1, 6'h00, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
      default: return '{PSS_OP_TERM, 1'b1, 6'h00, 7'h00, 7'h00, 16'h0000, 16'h0000, 16'h0000};
    endcase
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Waits for the end of a scan and checks the reference counts
  task automatic wait_scan(input int body, input logic per, input string name);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
    chk(n < 4000, 1'b1);
    chk(ic, 129);
    chk(wc, 129);
    chk(bc, body);
    chk(pcnt > 0, per);
    ic = 0;
    wc = 0;
    bc = 0;
    pcnt = 0;
    oimg <= seed[15:0];
    $display("test %s done", name);
    @(negedge clock_i);
  endtask
  // ==========================================
  // Inputs and program memory move on the falling edge
  always @(negedge clock_i) begin
    seed = lfsr(seed);
    rnd <= seed[1:0];
    instr <= prog(pc);
  end
  // Reference model: expected slot order and stored words
  always @(posedge clock_i) begin
    if (!reset_i && in_st.valid) begin
      es = ic < 128 ? ic : 5;
      chk(in_st.addr, es);
      chk(in_st.data, {1'b0, es[6:0], 8'hA5});
      ic++;
    end
    if (!reset_i && ack && req.valid && req.write) begin
      chk(req.slot, wc == 0 ? 3 : wc - 1);
      chk(wdata, oimg);
      chk(ic, 129);
      // Output refresh holds its program place, reached again after any routine return
      if (wc == 0) begin
        chk(pc, 16'h0002);
      end
      wc++;
    end
    if (!reset_i && dst.valid && dst.addr[15:8] == 8'h01) begin
      chk(dst.data, {8'h80, 8'h10 + dst.addr[7:0]});
      bc++;
    end else if (!reset_i && dst.valid) begin
      chk({dst.addr, dst.data}, 32'h0200_8120);
      pcnt++;
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (5) @(negedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk({running, werr, req.valid, done}, 4'h0);
    run_i <= 1'b1;
    @(negedge clock_i);
    run_i <= 1'b0;
    wait_scan(3, 1'b0, "plain");
    cond <= 1'b1;
    flag <= 1'b1;
    wait_scan(6, 1'b1, "invoke");
    flag <= 1'b0;
    wait_scan(6, 1'b0, "masked");
    stall <= 1'b1;
    n = 0;
    while (werr !== 1'b1 && n < 8000) begin
      @(negedge clock_i);
      n++;
    end
    chk(n < 8000, 1'b1);
    chk(running, 1'b0);
    run_i <= 1'b1;
    @(negedge clock_i);
    run_i <= 1'b0;
    stall <= 1'b0;
    ic = 0;
    wc = 0;
    chk({werr, running}, 2'h1);
    $display("test watchdog done");
    wait_scan(6, 1'b0, "restart");
    wrap_up();
  end
  // Hang guard, well beyond four scans and one expiry
  initial begin
    #(8 * 40000);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
